// File: src/bus_line_map.vh
`ifndef BUS_LINE_MAP_VH
`define BUS_LINE_MAP_VH

// ----------------------------------------------------------------
// APB geometry
// ----------------------------------------------------------------
`define APB_AW            12
`define APB_DW            32
`define APB_SW            4
`define WORD_LSB          2

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_BUS_CTRL_TWO  12'h000
`define OFS_LINE_STATUS   12'h004

// ----------------------------------------------------------------
// Bus control two: field positions
// ----------------------------------------------------------------
`define BC2_WIDTH         8
`define BIT_SDA_LEVEL     5
`define BIT_SDA_GUARD     4
`define BIT_SCL_MON       3
`define BIT_RSVD_HI       2
`define BIT_SOFT_RST      1
`define BIT_RSVD_LO       0

// ----------------------------------------------------------------
// Reset and constant read values
// ----------------------------------------------------------------
`define RST_SDA_LEVEL     1'h1
`define RST_SOFT_RST      1'h0
`define GUARD_READ_VAL    1'h1
`define RSVD_READ_VAL     1'h1
`define GUARD_OPEN        1'h0
`define LINE_SEEN_RST     1'h1

// ----------------------------------------------------------------
// Line status: field positions
// ----------------------------------------------------------------
`define BIT_SDA_PIN       0
`define BIT_SCL_PIN       1

// ----------------------------------------------------------------
// Strobe lane holding the low byte
// ----------------------------------------------------------------
`define LANE_LOW          0

`endif

// File: src/sync_two_stage.v
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Two flip-flop synchroniser, async clear to a fixed level
// ----------------------------------------------------------------
module sync_two_stage #(
    parameter [0:0] INIT = 1'h0
) (
    // Clock and reset
    input  wire clk,
    input  wire rst_n,
    // Data
    input  wire d,
    output wire q
);

    reg stage1_r;
    reg stage2_r;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= INIT;
            stage2_r <= INIT;
        end else begin
            stage1_r <= d;
            stage2_r <= stage1_r;
        end
    end

    assign q = stage2_r;

endmodule

// File: src/line_override_ctrl.v
// How it works
// - Level 0 written with guard 0 makes the device pull SDA low.
// - Level 1 written with guard 0 releases SDA to the pull-up unless the engine pulls it low.
// - Reading the level bit returns the SDA level actually output.
// - Level bit changes only on a write whose guard bit is 0.
// - Guard bit stores nothing and always reads as 1.
// - Bit 3 is read-only and shows the SCL output level.
// - Bits 2 and 0 read as 1; writes to them do nothing.
// - Soft reset bit at 1 resets control logic, registers kept.
// - Soft reset recovers a hang without pin or register setup.
// - Level bit sits at bit 5 and resets to 1 (released).
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "bus_line_map.vh"

module line_override_ctrl (
    // Clock and reset
    input  wire                  CLOCK,
    input  wire                  RST_N,
    // APB slave
    input  wire                  PSEL,
    input  wire                  PENABLE,
    input  wire                  PWRITE,
    input  wire [`APB_AW-1:0]    PADDR,
    input  wire [`APB_DW-1:0]    PWDATA,
    input  wire [`APB_SW-1:0]    PSTRB,
    output wire [`APB_DW-1:0]    PRDATA,
    output wire                  PREADY,
    output wire                  PSLVERR,
    // Transfer engine side
    input  wire                  ENG_SDA_LEVEL,
    input  wire                  ENG_SCL_LEVEL,
    output wire                  CTRL_PART_RST,
    // SDA open-drain pin
    input  wire                  SDA_I,
    output wire                  SDA_O,
    output wire                  SDA_OE,
    // SCL open-drain pin
    input  wire                  SCL_I,
    output wire                  SCL_O,
    output wire                  SCL_OE
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Assert at once; release waits two edges so that every
    // flop leaves reset on the same clock edge
    wire rst_n;

    sync_two_stage #(
        .INIT (1'h0)
    ) u_rst_sync (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     (1'h1),
        .q     (rst_n)
    );

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    // Lines idle high on their pull-ups, so the synchronisers
    // clear high and show no false low after reset
    localparam PIN_COUNT = 2;

    wire [PIN_COUNT-1:0] pin_raw;
    wire [PIN_COUNT-1:0] pin_seen;

    assign pin_raw[`BIT_SDA_PIN] = SDA_I;
    assign pin_raw[`BIT_SCL_PIN] = SCL_I;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin_sync
            sync_two_stage #(
                .INIT (`LINE_SEEN_RST)
            ) u_pin_sync (
                .clk   (CLOCK),
                .rst_n (rst_n),
                .d     (pin_raw[gi]),
                .q     (pin_seen[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Word compare only; byte offset bits are ignored
    function addr_hit;
        input [`APB_AW-1:0] addr;
        input [`APB_AW-1:0] ofs;
        begin
            addr_hit = (addr[`APB_AW-1:`WORD_LSB] ==
                        ofs[`APB_AW-1:`WORD_LSB]);
        end
    endfunction

    wire hit_ctrl;
    wire hit_stat;
    wire hit_any;

    assign hit_ctrl = addr_hit(PADDR, `OFS_BUS_CTRL_TWO);
    assign hit_stat = addr_hit(PADDR, `OFS_LINE_STATUS);
    // Anything else answers with an error
    assign hit_any  = hit_ctrl | hit_stat;

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    reg                  pready_r;
    reg                  pslverr_r;
    reg  [`APB_DW-1:0]   prdata_r;
    reg                  pready_nxt;
    reg                  pslverr_nxt;
    reg  [`APB_DW-1:0]   prdata_nxt;

    wire setup_phase;
    wire access_done;
    wire ctrl_write;

    // Answer prepared in setup, so access completes with no wait
    assign setup_phase = PSEL & ~PENABLE;
    assign access_done = PSEL & PENABLE & pready_r;
    // Line status is read-only, so only control writes land
    assign ctrl_write  = access_done & PWRITE & hit_ctrl &
                         PSTRB[`LANE_LOW];

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    wire guard_open;
    wire level_write;

    assign guard_open  = (PWDATA[`BIT_SDA_GUARD] == `GUARD_OPEN);
    assign level_write = ctrl_write & guard_open;

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    reg  sda_level_r;
    reg  soft_rst_r;
    reg  sda_level_nxt;
    reg  soft_rst_nxt;

    always @* begin
        sda_level_nxt = sda_level_r;
        soft_rst_nxt  = soft_rst_r;
        if (level_write) begin
            sda_level_nxt = PWDATA[`BIT_SDA_LEVEL];
        end
        // Soft reset clears no register, it only holds the engine
        if (ctrl_write) begin
            soft_rst_nxt = PWDATA[`BIT_SOFT_RST];
        end
    end

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            sda_level_r <= `RST_SDA_LEVEL;
            soft_rst_r  <= `RST_SOFT_RST;
        end else begin
            sda_level_r <= sda_level_nxt;
            soft_rst_r  <= soft_rst_nxt;
        end
    end

    // ------------------------------------------------------------
    // Line drive
    // ------------------------------------------------------------
    // Engine held in reset has its drives ignored, so a hung
    // transfer lets go of both lines at once
    reg  sda_oe_r;
    reg  scl_oe_r;
    reg  pad_o_r;
    reg  ctrl_rst_r;
    wire eng_sda;
    wire eng_scl;
    wire sda_low;
    wire scl_low;

    // An engine held in soft reset counts as letting go
    function eng_release;
        input level;
        input mask;
        begin
            eng_release = level | mask;
        end
    endfunction

    assign eng_sda = eng_release(ENG_SDA_LEVEL, soft_rst_r);
    assign eng_scl = eng_release(ENG_SCL_LEVEL, soft_rst_r);
    assign sda_low = ~(sda_level_r & eng_sda);
    assign scl_low = ~eng_scl;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_r   <= 1'h0;
            scl_oe_r   <= 1'h0;
            pad_o_r    <= 1'h0;
            ctrl_rst_r <= 1'h0;
        end else begin
            sda_oe_r   <= sda_low;
            scl_oe_r   <= scl_low;
            pad_o_r    <= 1'h0;
            ctrl_rst_r <= soft_rst_r;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    reg [`BC2_WIDTH-1:0] ctrl_view;
    reg [`BC2_WIDTH-1:0] stat_view;

    // Level and SCL bits show the driven output levels, not stored values
    always @* begin
        ctrl_view = {`BC2_WIDTH{1'h0}};
        ctrl_view[`BIT_SDA_LEVEL] = ~sda_oe_r;
        ctrl_view[`BIT_SDA_GUARD] = `GUARD_READ_VAL;
        ctrl_view[`BIT_SCL_MON]   = ~scl_oe_r;
        ctrl_view[`BIT_RSVD_HI]   = `RSVD_READ_VAL;
        ctrl_view[`BIT_SOFT_RST]  = soft_rst_r;
        ctrl_view[`BIT_RSVD_LO]   = `RSVD_READ_VAL;
        stat_view = {`BC2_WIDTH{1'h0}};
        stat_view[`BIT_SDA_PIN]   = pin_seen[`BIT_SDA_PIN];
        stat_view[`BIT_SCL_PIN]   = pin_seen[`BIT_SCL_PIN];
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Upper bits belong to logic outside this block and read 0
    function [`APB_DW-1:0] reg_word;
        input [`BC2_WIDTH-1:0] view;
        begin
            reg_word = {{(`APB_DW-`BC2_WIDTH){1'h0}}, view};
        end
    endfunction

    always @* begin
        pready_nxt  = 1'h0;
        pslverr_nxt = 1'h0;
        prdata_nxt  = {`APB_DW{1'h0}};
        if (setup_phase) begin
            pready_nxt  = 1'h1;
            pslverr_nxt = ~hit_any;
            if (!PWRITE) begin
                if (hit_ctrl) begin
                    prdata_nxt = reg_word(ctrl_view);
                end else if (hit_stat) begin
                    prdata_nxt = reg_word(stat_view);
                end
            end
        end else if (PSEL & PENABLE & ~pready_r) begin
            // Access without a seen setup: answer next cycle
            pready_nxt  = 1'h1;
            pslverr_nxt = ~hit_any;
        end
    end

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pready_r  <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r  <= {`APB_DW{1'h0}};
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PRDATA        = prdata_r;
    assign PREADY        = pready_r;
    assign PSLVERR       = pslverr_r;
    assign CTRL_PART_RST = ctrl_rst_r;
    // O pins stay low; the enables alone move the lines
    assign SDA_O         = pad_o_r;
    assign SDA_OE        = sda_oe_r;
    assign SCL_O         = pad_o_r;
    assign SCL_OE        = scl_oe_r;

endmodule

// File: verif/line_override_monitor.sv
`timescale 1ns/100ps
`include "bus_line_map.vh"
module line_override_monitor (
    // Clock and reset
    input wire                 CLOCK,
    input wire                 RST_N,
    // APB
    input wire                 PSEL,
    input wire                 PENABLE,
    input wire                 PWRITE,
    input wire [`APB_AW-1:0]   PADDR,
    input wire [`APB_DW-1:0]   PWDATA,
    input wire [`APB_SW-1:0]   PSTRB,
    input wire [`APB_DW-1:0]   PRDATA,
    input wire                 PREADY,
    input wire                 PSLVERR,
    // Engine and lines
    input wire                 ENG_SDA_LEVEL,
    input wire                 CTRL_PART_RST,
    input wire                 SDA_OE,
    input wire                 SCL_OE
);
    wire acc;
    wire wr0;
    wire rd0;
    assign acc = PSEL && PENABLE && PREADY && PADDR == `OFS_BUS_CTRL_TWO;
    assign wr0 = acc && PWRITE && PSTRB[0];
    assign rd0 = acc && !PWRITE;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    AST_SDA_LOW: assert property (
        wr0 && !PWDATA[5] && !PWDATA[4] |-> ##2 SDA_OE)
        else $error("sda not pulled low");
    AST_SDA_REL: assert property (
        wr0 && PWDATA[5] && !PWDATA[4] ##1 ENG_SDA_LEVEL |=> !SDA_OE)
        else $error("sda not released");
    AST_LVL_READ: assert property (
        rd0 |-> PRDATA[5] == !$past(SDA_OE))
        else $error("level bit wrong");
    AST_GUARD_READ: assert property (rd0 |-> PRDATA[4])
        else $error("guard bit not one");
    AST_SCL_MON: assert property (
        rd0 |-> PRDATA[3] == !$past(SCL_OE))
        else $error("scl monitor wrong");
    AST_RSVD: assert property (rd0 |-> PRDATA[2] && PRDATA[0])
        else $error("reserved bits wrong");
    AST_RST_FOLLOW: assert property (
        wr0 |-> ##2 CTRL_PART_RST == $past(PWDATA[1], 2))
        else $error("soft reset output wrong");
    AST_RST_MASK: assert property (CTRL_PART_RST |-> !SCL_OE)
        else $error("scl driven in soft reset");
    AST_GUARD_HOLD: assert property (
        wr0 && PWDATA[4] && !SDA_OE ##1 ENG_SDA_LEVEL |=> !SDA_OE)
        else $error("guarded write moved sda");
    AST_ZERO_WAIT: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
endmodule
bind line_override_ctrl line_override_monitor line_override_monitor_i (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ENG_SDA_LEVEL(ENG_SDA_LEVEL), .CTRL_PART_RST(CTRL_PART_RST),
    .SDA_OE(SDA_OE), .SCL_OE(SCL_OE));

// File: verif/i2c_line_model.sv
`timescale 1ns/100ps
module i2c_line_model (
    input  wire sda_oe,
    input  wire scl_oe,
    output wire sda_line,
    output wire scl_line
);
    // Pull-ups win whenever nobody pulls low
    assign sda_line = !sda_oe;
    assign scl_line = !scl_oe;
endmodule

// File: verif/line_override_ctrl_tb.sv
`timescale 1ns/100ps
`include "bus_line_map.vh"
module line_override_ctrl_tb;
    reg         clk = 1'h0;
    reg         rst_n = 1'h0;
    reg         psel = 1'h0;
    reg         penable = 1'h0;
    reg         pwrite = 1'h0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    // engine idle, so level moves are safe
    reg         eng_scl = 1'h1;
    reg         eng_sda = 1'h1;
    reg  [3:0]  pstrb = 4'hF;
    reg  [31:0] rd;
    reg         err;
    integer     errors = 0;
    integer     cmp_count = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, ctrl_rst, sda_oe, scl_oe, sda_w, scl_w;
    always #5 clk = ~clk;
    line_override_ctrl line_override_ctrl_i (.CLOCK(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ENG_SDA_LEVEL(eng_sda), .ENG_SCL_LEVEL(eng_scl),
        .CTRL_PART_RST(ctrl_rst), .SDA_I(sda_w), .SDA_O(), .SDA_OE(sda_oe),
        .SCL_I(scl_w), .SCL_O(), .SCL_OE(scl_oe));
    i2c_line_model i2c_line_model_i (.sda_oe(sda_oe), .scl_oe(scl_oe),
        .sda_line(sda_w), .scl_line(scl_w));
    task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("[ERR] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'h1;
            @(posedge clk);
            while (pready !== 1'h1) begin
                @(posedge clk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] e);
        begin
            apb(1'h0, a, 32'h0);
            chk("prdata", e, rd);
        end
    endtask
    task t_reset;
        begin
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3D);
            rdchk(`OFS_LINE_STATUS, 32'h3);
        end
    endtask
    task t_sda;
        begin
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h00);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h1D);
            chk("sda_line", 32'h0, {31'h0, sda_w});
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h30);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h1D);
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h20);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3D);
            chk("sda_line", 32'h1, {31'h0, sda_w});
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h10);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3D);
            pstrb <= 4'hE;
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h00);
            pstrb <= 4'hF;
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3D);
        end
    endtask
    task t_soft_rst;
        begin
            eng_sda <= 1'h0;
            eng_scl <= 1'h0;
            rdchk(`OFS_BUS_CTRL_TWO, 32'h15);
            chk("sda_line", 32'h0, {31'h0, sda_w});
            rdchk(`OFS_LINE_STATUS, 32'h0);
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h16);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3F);
            chk("ctrl_rst", 32'h1, {31'h0, ctrl_rst});
            chk("scl_line", 32'h1, {31'h0, scl_w});
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h10);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h15);
            chk("ctrl_rst", 32'h0, {31'h0, ctrl_rst});
            eng_sda <= 1'h1;
            eng_scl <= 1'h1;
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3D);
        end
    endtask
    task t_unmapped;
        begin
            apb(1'h0, 12'h008, 32'h0);
            chk("pslverr", 32'h1, {31'h0, err});
            chk("prdata", 32'h0, rd);
        end
    endtask
    task t_hw_reset;
        begin
            apb(1'h1, `OFS_BUS_CTRL_TWO, 32'h02);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h1F);
            rst_n <= 1'h0;
            repeat (2) @(posedge clk);
            rst_n <= 1'h1;
            repeat (3) @(posedge clk);
            rdchk(`OFS_BUS_CTRL_TWO, 32'h3D);
            chk("ctrl_rst", 32'h0, {31'h0, ctrl_rst});
        end
    endtask
    task report_and_stop;
        begin
            if (errors == 0 && cmp_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        errors = errors + 1;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        t_reset;
        t_sda;
        t_soft_rst;
        t_unmapped;
        t_hw_reset;
        report_and_stop;
    end
endmodule
